/* cgs_pkg.sv */
// Summary of operation
// - Above 15 percent error, coarse steps double or halve period in eight corrections.
// - Between 15 and 5 percent, medium steps; at most eight corrections needed.
// - Internal clock stable flag sets when error first falls within 5 percent.
// - Below 5 percent, minimum-size steps; at most 24 corrections to minimum error.
// - Each correction lasts the same time; 32 corrections total about 128 base periods.
// - Capacitor is 384 fixed units plus 8-bit trim; trim resets to 128.
// - Each added trim unit lowers base frequency about 0.195 percent.
// - Generator keeps running in wait; its enabled interrupt wakes the processor.
// - Stop without run option halts generator and holds all output clocks low.
// - Stop with run option keeps generator running; its interrupts never wake.
// - Stop without run option clears external and internal clock stable flags.
// - Stop without run option turns monitor off, clearing its enable and flag.
// - Stop leaves select, external enable, multiplier and trim intact; divider and stage hold only in stop without run option.
// - External generator enable settable only while external input option is set.
// - External generator enable opens the external clock path through shared pin.
// - Every clock option has a defined default; external input option defaults clear.
// - Each loop correction spans four low-frequency base clock periods.
// - Internal fast clock equals multiplier times base clock of nominally 307.2 kHz.
package cgs_pkg;
	// Reference and base clock rates
	localparam int REF_CLK_KHZ = 100000;
	localparam int BASE_HZ = 307200;
	localparam int BASE_CYC = (REF_CLK_KHZ * 1000) / BASE_HZ;
	// Capacitor and trim
	localparam logic [9:0] CAP_FIXED = 10'h180;
	localparam logic [9:0] CAP_NOMINAL = 10'h200;
	localparam int CAP_NOMINAL_LOG2 = 9;
	localparam logic [7:0] RESET_TRIM = 8'h80;
	localparam logic [6:0] RESET_MULT = 7'h15;
	// Loop filter
	localparam logic [2:0] CORR_BASE_TICKS = 3'h4;
	localparam logic [7:0] COARSE_STEP = 8'h20;
	localparam logic [7:0] MEDIUM_STEP = 8'h08;
	localparam logic [7:0] FINE_STEP = 8'h01;
	localparam logic [3:0] DIV_MAX = 4'h9;
	localparam logic [7:0] RESET_STAGE = 8'h00;
	localparam logic [3:0] RESET_DIV = 4'h0;
	localparam logic [4:0] FINE_MAX = 5'h18;
	localparam logic [5:0] TOTAL_CORR = 6'h20;
	localparam logic [4:0] EXT_STAB_EDGES = 5'h10;
	// Comparator error bands
	localparam logic [1:0] BAND_FINE = 2'h0;
	localparam logic [1:0] BAND_MEDIUM = 2'h1;
	// Loop filter phases
	typedef enum logic [2:0] {
		PH_COARSE = 3'b001,
		PH_MEDIUM = 3'b010,
		PH_FINE = 3'b100
	} cgs_phase_t;
endpackage

/* cgs_base_gen.sv */
`timescale 1ns/1ps
module cgs_base_gen (
	input wire logic i_ref_clk, // System clock
	input wire logic i_rst, // Async reset, high
	input wire logic i_run, // Generator active
	input wire logic [7:0] i_trim, // Trim factor
	input wire logic [6:0] i_mult, // Multiplier factor
	output logic o_base_tick, // Base clock period pulse
	output logic o_fast_tick, // Fast clock half-period pulse
	output logic [9:0] o_cap_units // Capacitor size
);
	logic [17:0] limit;
	logic [17:0] base_cnt;
	logic [17:0] fast_acc;
	logic [17:0] fast_sum;

	// Larger capacitor stretches base period, so trim up slows the clock
	assign limit = 18'((18'(cgs_pkg::BASE_CYC) * 18'(o_cap_units)) >> cgs_pkg::CAP_NOMINAL_LOG2);
	// Two ticks per fast period, one for each edge of the fast clock;
	// small capacitor with a large multiplier saturates at one tick per cycle
	assign fast_sum = fast_acc + 18'({i_mult, 1'b0});

	// Capacitor units follow trim
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			o_cap_units <= cgs_pkg::CAP_NOMINAL;
		else
			o_cap_units <= cgs_pkg::CAP_FIXED + 10'(i_trim);
	end

	// Base period counter, held at zero while generator stops
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			base_cnt <= 18'h0;
			o_base_tick <= 1'b0;
		end else if (!i_run) begin
			base_cnt <= 18'h0;
			o_base_tick <= 1'b0;
		end else if (base_cnt + 18'h1 >= limit) begin
			base_cnt <= 18'h0;
			o_base_tick <= 1'b1;
		end else begin
			base_cnt <= base_cnt + 18'h1;
			o_base_tick <= 1'b0;
		end
	end

	// Fractional accumulator gives two ticks per base period for each multiplier unit
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			fast_acc <= 18'h0;
			o_fast_tick <= 1'b0;
		end else if (!i_run) begin
			fast_acc <= 18'h0;
			o_fast_tick <= 1'b0;
		end else if (fast_sum >= limit) begin
			fast_acc <= fast_sum - limit;
			o_fast_tick <= 1'b1;
		end else begin
			fast_acc <= fast_sum;
			o_fast_tick <= 1'b0;
		end
	end
endmodule // cgs_base_gen

/* cgs_clock_gen.sv */
`timescale 1ns/1ps
module cgs_clock_gen (
	input wire logic i_ref_clk, // System clock, 100 MHz
	input wire logic i_rst, // Async reset, high
	input wire logic [1:0] i_err_band, // Comparator error band, async
	input wire logic i_err_slow, // Clock too slow, async
	input wire logic i_mult_wr, // Multiplier write strobe
	input wire logic [6:0] i_mult_data, // Multiplier write value
	input wire logic i_trim_wr, // Trim write strobe
	input wire logic [7:0] i_trim_data, // Trim write value
	input wire logic i_clock_sel, // 1 selects external clock
	input wire logic i_ext_gen_req, // Requested external enable
	input wire logic i_monitor_req, // Requested monitor on
	input wire logic i_monitor_irq_en_req, // Requested monitor irq enable
	input wire logic i_monitor_fail, // Monitor saw dead clock
	input wire logic i_monitor_flag_clr, // Clear monitor flag
	input wire logic i_idle, // Wait mode
	input wire logic i_halt, // Stop mode
	input wire logic i_run_in_halt_option, // Keep running in stop
	input wire logic i_ext_input_allow_option, // Allow external input
	input wire logic i_ext_clk_pin, // Shared oscillator pin, async
	output logic o_internal_clock_stable, // Within 5 percent
	output logic o_external_clock_stable, // External clock settled
	output logic o_settled, // Minimum error reached
	output logic o_monitor_on, // Monitor running
	output logic o_monitor_irq_enable, // Monitor irq enable
	output logic o_monitor_irq_flag, // Monitor irq flag
	output logic o_external_gen_on, // External generator enabled
	output logic o_pin_is_port, // Shared pin acts as port
	output logic o_wake, // Wake request to core
	output logic o_selected_raw_clock, // Raw selected clock
	output logic o_bus_clock_out, // Bus clock
	output logic o_watchdog_clock, // Watchdog clock
	output logic o_timebase_clock, // Timebase clock
	output logic [7:0] o_stage_ctrl, // Oscillator stage control
	output logic [3:0] o_divider_ctrl, // Oscillator divider control
	output logic [7:0] o_trim, // Trim factor
	output logic [6:0] o_mult, // Multiplier factor
	output logic [9:0] o_cap_units // Capacitor size
);
	cgs_pkg::cgs_phase_t phase;
	logic [1:0] band_s1, band_s2;
	logic slow_s1, slow_s2;
	logic pin_s1, pin_s2, pin_d;
	logic halted;
	logic run;
	logic base_tick, fast_tick;
	logic [2:0] tick_cnt;
	logic corr;
	logic [5:0] corr_cnt;
	logic [4:0] fine_cnt;
	logic [4:0] ext_cnt;
	logic [2:0] bus_div;
	logic fast_clk;
	logic [8:0] next_sum;
	logic [7:0] step;
	logic opt_ext, opt_run;

	// Generator shut down only for stop without the run option
	assign halted = i_halt && !opt_run;
	assign run = !halted;
	assign corr = base_tick && (tick_cnt == cgs_pkg::CORR_BASE_TICKS - 3'h1);

	// Two-stage synchronisers for comparator and pin inputs
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			band_s1 <= 2'h0;
			band_s2 <= 2'h0;
			slow_s1 <= 1'b0;
			slow_s2 <= 1'b0;
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_d <= 1'b0;
		end else begin
			band_s1 <= i_err_band;
			band_s2 <= band_s1;
			slow_s1 <= i_err_slow;
			slow_s2 <= slow_s1;
			pin_s1 <= i_ext_clk_pin;
			pin_s2 <= pin_s1;
			pin_d <= pin_s2;
		end
	end

	// Options reset clear and follow their inputs every cycle out of reset
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			opt_ext <= 1'b0;
			opt_run <= 1'b0;
		end else begin
			opt_ext <= i_ext_input_allow_option;
			opt_run <= i_run_in_halt_option;
		end
	end

	cgs_base_gen u_base (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_run(run),
		.i_trim(o_trim),
		.i_mult(o_mult),
		.o_base_tick(base_tick),
		.o_fast_tick(fast_tick),
		.o_cap_units(o_cap_units)
	);

	// Multiplier and trim; stop does not touch them
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mult <= cgs_pkg::RESET_MULT;
			o_trim <= cgs_pkg::RESET_TRIM;
		end else begin
			if (i_mult_wr)
				o_mult <= i_mult_data;
			if (i_trim_wr)
				o_trim <= i_trim_data;
		end
	end

	// Correction pacing: four base periods each
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			tick_cnt <= 3'h0;
		else if (corr)
			tick_cnt <= 3'h0;
		else if (base_tick)
			tick_cnt <= tick_cnt + 3'h1;
	end

	// Phase tracks the band every cycle, so a correction uses the step of
	// the band it is made in, not that of the correction before
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			phase <= cgs_pkg::PH_COARSE;
		else begin
			if (band_s2 == cgs_pkg::BAND_FINE)
				phase <= cgs_pkg::PH_FINE;
			else if (band_s2 == cgs_pkg::BAND_MEDIUM)
				phase <= cgs_pkg::PH_MEDIUM;
			else
				phase <= cgs_pkg::PH_COARSE;
		end
	end

	// Step size per phase
	always_comb begin
		unique case (phase)
			cgs_pkg::PH_COARSE: step = cgs_pkg::COARSE_STEP;
			cgs_pkg::PH_MEDIUM: step = cgs_pkg::MEDIUM_STEP;
			cgs_pkg::PH_FINE: step = cgs_pkg::FINE_STEP;
			default: step = cgs_pkg::FINE_STEP;
		endcase
	end
	assign next_sum = slow_s2 ? {1'b0, o_stage_ctrl} - {1'b0, step}
		: {1'b0, o_stage_ctrl} + {1'b0, step};

	// Stage moves by step; carry or borrow shifts the divider, and at
	// divider 9 or 0 the stage saturates instead
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_stage_ctrl <= cgs_pkg::RESET_STAGE;
			o_divider_ctrl <= cgs_pkg::RESET_DIV;
		end else if (corr) begin
			if (!next_sum[8])
				o_stage_ctrl <= next_sum[7:0];
			else if (!slow_s2 && o_divider_ctrl == cgs_pkg::DIV_MAX)
				o_stage_ctrl <= 8'hff;
			else if (slow_s2 && o_divider_ctrl == 4'h0)
				o_stage_ctrl <= 8'h00;
			else begin
				o_stage_ctrl <= next_sum[7:0];
				o_divider_ctrl <= slow_s2 ? o_divider_ctrl - 4'h1
					: o_divider_ctrl + 4'h1;
			end
		end
	end

	// Settling counters restart on a multiplier or trim write, or on stop without the run option
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			corr_cnt <= 6'h0;
			fine_cnt <= 5'h0;
			o_settled <= 1'b0;
		end else if (i_mult_wr || i_trim_wr || halted) begin
			corr_cnt <= 6'h0;
			fine_cnt <= 5'h0;
			o_settled <= 1'b0;
		end else if (corr && phase != cgs_pkg::PH_COARSE) begin
			if (corr_cnt != cgs_pkg::TOTAL_CORR)
				corr_cnt <= corr_cnt + 6'h1;
			if (phase == cgs_pkg::PH_FINE && fine_cnt != cgs_pkg::FINE_MAX)
				fine_cnt <= fine_cnt + 5'h1;
			if (phase == cgs_pkg::PH_FINE && fine_cnt == cgs_pkg::FINE_MAX - 5'h1)
				o_settled <= 1'b1;
		end
	end

	// Stable once the loop first reaches the fine band
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			o_internal_clock_stable <= 1'b0;
		else if (halted || i_mult_wr || i_trim_wr)
			o_internal_clock_stable <= 1'b0;
		else if (corr && band_s2 == cgs_pkg::BAND_FINE)
			o_internal_clock_stable <= 1'b1;
	end

	// External enable gated by option; pin path follows it
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_external_gen_on <= 1'b0;
			o_pin_is_port <= 1'b1;
		end else begin
			o_external_gen_on <= i_ext_gen_req && opt_ext;
			o_pin_is_port <= !(i_ext_gen_req && opt_ext);
		end
	end

	// Stabilisation divider counts external edges again after stop without the run option
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_cnt <= 5'h0;
			o_external_clock_stable <= 1'b0;
		end else if (halted || !o_external_gen_on) begin
			ext_cnt <= 5'h0;
			o_external_clock_stable <= 1'b0;
		end else if (pin_s2 && !pin_d && !o_external_clock_stable) begin
			ext_cnt <= ext_cnt + 5'h1;
			if (ext_cnt == cgs_pkg::EXT_STAB_EDGES - 5'h1)
				o_external_clock_stable <= 1'b1;
		end
	end

	// Monitor bits; a new failure wins over a clear in the same cycle
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_monitor_on <= 1'b0;
			o_monitor_irq_enable <= 1'b0;
			o_monitor_irq_flag <= 1'b0;
		end else if (halted || !i_monitor_req) begin
			o_monitor_on <= 1'b0;
			o_monitor_irq_enable <= 1'b0;
			o_monitor_irq_flag <= 1'b0;
		end else begin
			o_monitor_on <= 1'b1;
			o_monitor_irq_enable <= i_monitor_irq_en_req && o_monitor_on;
			if (o_monitor_on && i_monitor_fail)
				o_monitor_irq_flag <= 1'b1;
			else if (i_monitor_flag_clr)
				o_monitor_irq_flag <= 1'b0;
		end
	end

	// Interrupt wakes from wait only, never from stop
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			o_wake <= 1'b0;
		else
			o_wake <= i_idle && !i_halt && o_monitor_irq_enable && o_monitor_irq_flag;
	end

	// Output clocks; forced low while halted; bus clock is the raw clock over four
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			fast_clk <= 1'b0;
			bus_div <= 3'h0;
			o_selected_raw_clock <= 1'b0;
			o_bus_clock_out <= 1'b0;
			o_watchdog_clock <= 1'b0;
			o_timebase_clock <= 1'b0;
		end else if (halted) begin
			fast_clk <= 1'b0;
			bus_div <= 3'h0;
			o_selected_raw_clock <= 1'b0;
			o_bus_clock_out <= 1'b0;
			o_watchdog_clock <= 1'b0;
			o_timebase_clock <= 1'b0;
		end else begin
			if (fast_tick)
				fast_clk <= !fast_clk;
			o_selected_raw_clock <= i_clock_sel && o_external_gen_on ? pin_s2 : fast_clk;
			if (o_selected_raw_clock != (i_clock_sel && o_external_gen_on ? pin_s2 : fast_clk))
				bus_div <= bus_div + 3'h1;
			o_bus_clock_out <= bus_div[2];
			o_watchdog_clock <= o_selected_raw_clock;
			o_timebase_clock <= o_selected_raw_clock;
		end
	end

	a_halt_clocks_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$past(halted) && halted |-> !o_bus_clock_out && !o_selected_raw_clock && !o_timebase_clock
			&& !o_watchdog_clock)
		else $error("output clock active in stop");
	a_halt_clears_stable: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		halted |=> !o_internal_clock_stable && !o_external_clock_stable)
		else $error("stable flag survived stop");
	a_halt_monitor_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		halted |=> !o_monitor_on && !o_monitor_irq_enable && !o_monitor_irq_flag)
		else $error("monitor active in stop");
	a_ext_gate_option: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!opt_ext |=> !o_external_gen_on && o_pin_is_port)
		else $error("external enable set without option");
	a_stop_keeps_trim: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_halt && !i_trim_wr && !i_mult_wr |=> $stable(o_trim) && $stable(o_mult))
		else $error("stop altered settings");
	a_corr_four_bases: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$changed({o_divider_ctrl, o_stage_ctrl}) |-> $past(base_tick) && $past(tick_cnt) == 3'h3)
		else $error("correction not on fourth base tick");
	a_stable_on_fine: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!o_internal_clock_stable ##1 o_internal_clock_stable |-> $past(corr) && $past(band_s2) == 2'h0)
		else $error("stable set outside fine band");
	a_no_wake_in_stop: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_halt |=> !o_wake)
		else $error("wake raised in stop");
	a_wait_wake: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_idle && !i_halt && o_monitor_irq_enable && o_monitor_irq_flag |=> o_wake)
		else $error("missing wake in wait");
	a_trim_reset: assert property (@(posedge i_ref_clk)
		$fell(i_rst) |-> o_trim == 8'h80 && o_cap_units == 10'h200)
		else $error("trim reset value wrong");
	a_settled_after_fine: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(o_settled) |-> fine_cnt == 5'h18 && o_internal_clock_stable && corr_cnt <= 6'h20)
		else $error("settled too early");
endmodule // cgs_clock_gen

/* cgs_comparator_model.sv */
`timescale 1ns/1ps
// Comparator stand-in: the error band follows the corrections made since a restart
module cgs_comparator_model (
	input wire logic i_ref_clk, // System clock
	input wire logic i_rst, // Async reset, high
	input wire logic i_restart, // Settling restarted
	input wire logic [7:0] i_coarse_n, // Corrections spent above 15 percent
	input wire logic [11:0] i_ctl, // Divider and stage from the loop
	output logic [1:0] o_err_band, // Error band to the loop
	output logic o_err_slow // Clock too slow
);
	logic [7:0] seen;
	logic [11:0] last;
	// A moved loop output marks one correction
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			seen <= 8'h00;
			last <= 12'h000;
		end else begin
			last <= i_ctl;
			if (i_restart)
				seen <= 8'h00;
			else if (last != i_ctl && seen != 8'hff)
				seen <= seen + 8'h01;
		end
	end
	// Coarse first, then at most eight medium, then fine for good
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			o_err_band <= 2'h2;
		else if (seen < i_coarse_n)
			o_err_band <= 2'h2;
		else if (seen < i_coarse_n + 8'h08)
			o_err_band <= 2'h1;
		else
			o_err_band <= 2'h0;
	end
	// Always too fast, so the loop only lengthens; keeps carries predictable
	assign o_err_slow = 1'b0;
endmodule // cgs_comparator_model

/* cgs_clock_gen_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITC(c, n) begin wcnt = 0; while ((c) !== 1'b1 && wcnt < (n)) begin \
	@(posedge i_ref_clk); wcnt++; end if ((c) !== 1'b1) begin err_total++; \
	$display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1); end_of_test(); end end
module cgs_clock_gen_test;
	logic i_ref_clk, i_rst, i_trim_wr, i_ext_gen_req, i_monitor_req, i_monitor_irq_en_req;
	logic i_monitor_fail, i_monitor_flag_clr, i_idle, i_halt, i_run_in_halt_option;
	logic i_ext_input_allow_option;
	logic i_ext_clk_pin, i_err_slow, cmp_restart, meas, have_prev;
	logic [7:0] i_trim_data;
	logic [1:0] i_err_band;
	logic o_internal_clock_stable, o_external_clock_stable, o_settled, o_monitor_on;
	logic o_monitor_irq_enable, o_monitor_irq_flag, o_external_gen_on, o_pin_is_port, o_wake;
	logic o_selected_raw_clock, o_bus_clock_out, o_watchdog_clock, o_timebase_clock, prev;
	logic [7:0] o_stage_ctrl, o_trim;
	logic [3:0] o_divider_ctrl;
	logic [6:0] o_mult;
	logic [9:0] o_cap_units;
	logic [11:0] prev_ctl, save;
	logic [2:0] pin_cnt = 3'h0;
	int err_total = 0, compares = 0, wcnt, n, k, ncorr = 0, gap = 0, exp_gap, cap_exp;
	cgs_clock_gen cgs_clock_gen_i (.i_ref_clk, .i_rst, .i_err_band, .i_err_slow,
		.i_mult_wr(1'b0), .i_mult_data(7'h15), .i_trim_wr, .i_trim_data, .i_clock_sel(1'b0),
		.i_ext_gen_req, .i_monitor_req, .i_monitor_irq_en_req, .i_monitor_fail,
		.i_monitor_flag_clr, .i_idle, .i_halt, .i_run_in_halt_option,
		.i_ext_input_allow_option, .i_ext_clk_pin, .o_internal_clock_stable,
		.o_external_clock_stable, .o_settled, .o_monitor_on, .o_monitor_irq_enable,
		.o_monitor_irq_flag, .o_external_gen_on, .o_pin_is_port, .o_wake, .o_selected_raw_clock,
		.o_bus_clock_out, .o_watchdog_clock, .o_timebase_clock, .o_stage_ctrl, .o_divider_ctrl,
		.o_trim, .o_mult, .o_cap_units);
	cgs_comparator_model cgs_comparator_model_i (.i_ref_clk, .i_rst, .i_restart(cmp_restart),
		.i_coarse_n(8'h03), .i_ctl({o_divider_ctrl, o_stage_ctrl}), .o_err_band(i_err_band),
		.o_err_slow(i_err_slow));
	// 100 MHz reference
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	// External clock on the shared pin, one eighth of the reference
	always @(posedge i_ref_clk) pin_cnt <= pin_cnt + 3'h1;
	assign i_ext_clk_pin = pin_cnt[2];
	function automatic logic [11:0] step_of(input logic [1:0] b);
		if (b == 2'h0)
			return {4'h0, cgs_pkg::FINE_STEP};
		else if (b == 2'h1)
			return {4'h0, cgs_pkg::MEDIUM_STEP};
		return {4'h0, cgs_pkg::COARSE_STEP};
	endfunction
	// Every loop move: size set by the band, spacing by four base periods
	always @(posedge i_ref_clk) begin
		gap++;
		if (meas !== 1'b1) begin
			have_prev = 1'b0;
		end else if ({o_divider_ctrl, o_stage_ctrl} !== prev_ctl) begin
			exp_gap = 4 * cgs_pkg::BASE_CYC * cap_exp / 512;
			if (have_prev) begin
				`CHK(12'({o_divider_ctrl, o_stage_ctrl} - prev_ctl), step_of(i_err_band))
				`CHK(gap > exp_gap - 8 && gap < exp_gap + 8, 1'b1)
			end
			have_prev = 1'b1;
			gap = 0;
			ncorr++;
		end
		prev_ctl = {o_divider_ctrl, o_stage_ctrl};
	end
	task automatic end_of_test();
		if (err_total == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Trim load; restarts settling, so the comparator restarts too
	task automatic trim_write(input logic [7:0] v);
		@(posedge i_ref_clk);
		i_trim_wr <= 1'b1;
		i_trim_data <= v;
		cmp_restart <= 1'b1;
		@(posedge i_ref_clk);
		i_trim_wr <= 1'b0;
		cmp_restart <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		#1;
	endtask
	initial begin
		{i_trim_wr, i_ext_gen_req, i_monitor_req, i_monitor_irq_en_req, i_monitor_fail} = 5'h00;
		{i_idle, i_halt, i_run_in_halt_option, i_ext_input_allow_option, i_monitor_flag_clr} = 5'h00;
		{cmp_restart, meas, have_prev} = 3'h0;
		i_trim_data = 8'h80;
		cap_exp = 512;
		i_rst = 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		meas <= 1'b1;
		#1;
		`CHK({o_trim, o_cap_units}, {8'h80, 10'h200})
		`CHK(o_mult, 7'h15)
		`CHK({o_external_gen_on, o_pin_is_port}, 2'h1)
		`CHK({o_internal_clock_stable, o_external_clock_stable}, 2'h0)
		@(posedge i_ref_clk);
		i_ext_gen_req <= 1'b1;
		repeat (6) @(posedge i_ref_clk);
		#1;
		`CHK({o_external_gen_on, o_pin_is_port}, 2'h1)
		@(posedge i_ref_clk);
		i_ext_input_allow_option <= 1'b1;
		`WAITC(o_external_gen_on, 10)
		`WAITC(o_pin_is_port === 1'b0, 10)
		`WAITC(o_external_clock_stable, 400)
		// Settling from reset: 3 coarse, 8 medium, then fine
		`WAITC(o_internal_clock_stable, 20000)
		#1;
		`CHK(ncorr >= 11, 1'b1)
		`CHK(o_settled, 1'b0)
		`WAITC(o_settled, 32500)
		@(posedge i_ref_clk);
		meas <= 1'b0;
		i_idle <= 1'b1;
		i_monitor_req <= 1'b1;
		`WAITC(o_monitor_on, 10)
		@(posedge i_ref_clk);
		i_monitor_irq_en_req <= 1'b1;
		`WAITC(o_monitor_irq_enable, 10)
		#1;
		`CHK(o_wake, 1'b0)
		// Failure beats a clear in the same cycle
		@(posedge i_ref_clk);
		{i_monitor_fail, i_monitor_flag_clr} <= 2'h3;
		@(posedge i_ref_clk);
		{i_monitor_fail, i_monitor_flag_clr} <= 2'h0;
		`WAITC(o_wake, 10)
		// A lone clear drops flag and wake; a new failure raises them again
		@(posedge i_ref_clk);
		i_monitor_flag_clr <= 1'b1;
		@(posedge i_ref_clk);
		i_monitor_flag_clr <= 1'b0;
		`WAITC(o_wake === 1'b0, 10)
		`CHK(o_monitor_irq_flag, 1'b0)
		@(posedge i_ref_clk);
		i_monitor_fail <= 1'b1;
		@(posedge i_ref_clk);
		i_monitor_fail <= 1'b0;
		`WAITC(o_wake, 10)
		// Stop with the run option: clocks go on, no wake
		@(posedge i_ref_clk);
		i_run_in_halt_option <= 1'b1;
		@(posedge i_ref_clk);
		i_halt <= 1'b1;
		`WAITC(o_wake === 1'b0, 10)
		n = 0;
		prev = o_bus_clock_out;
		repeat (400) begin
			@(posedge i_ref_clk);
			if (o_bus_clock_out !== prev) n++;
			prev = o_bus_clock_out;
		end
		`CHK(n > 2, 1'b1)
		`CHK(o_wake, 1'b0)
		// Option dropped while stopped: everything halts low and frozen
		@(posedge i_ref_clk);
		i_run_in_halt_option <= 1'b0;
		`WAITC({o_selected_raw_clock, o_bus_clock_out, o_watchdog_clock, o_timebase_clock} === 4'h0, 50)
		save = {o_divider_ctrl, o_stage_ctrl};
		n = 0;
		repeat (3000) begin
			@(posedge i_ref_clk);
			if ({o_selected_raw_clock, o_bus_clock_out, o_watchdog_clock, o_timebase_clock,
				o_divider_ctrl, o_stage_ctrl} !== {4'h0, save}) n++;
		end
		#1;
		`CHK(n, 0)
		`CHK({o_internal_clock_stable, o_external_clock_stable}, 2'h0)
		`CHK({o_monitor_on, o_monitor_irq_enable, o_monitor_irq_flag}, 3'h0)
		`CHK({o_external_gen_on, o_trim, o_mult}, {1'b1, 8'h80, 7'h15})
		`CHK(o_wake, 1'b0)
		@(posedge i_ref_clk);
		i_halt <= 1'b0;
		i_idle <= 1'b0;
		i_monitor_req <= 1'b0;
		i_monitor_irq_en_req <= 1'b0;
		// Trim extremes, then the slower base clock with a full capacitor
		trim_write(8'h00);
		`CHK({o_trim, o_cap_units}, {8'h00, 10'h180})
		trim_write(8'hff);
		`CHK({o_trim, o_cap_units}, {8'hff, 10'h27f})
		`CHK(o_internal_clock_stable, 1'b0)
		cap_exp = 639;
		meas <= 1'b1;
		k = ncorr;
		`WAITC(ncorr >= k + 3, 6000)
		// Four base periods hold four times the multiplier in fast periods, two edges each
		n = 0;
		prev = o_selected_raw_clock;
		repeat (exp_gap) begin
			@(posedge i_ref_clk);
			if (o_selected_raw_clock !== prev) n++;
			prev = o_selected_raw_clock;
		end
		`CHK(n > 8 * cgs_pkg::RESET_MULT - 3 && n < 8 * cgs_pkg::RESET_MULT + 3, 1'b1)
		end_of_test();
	end
endmodule // cgs_clock_gen_test
